// ### tb/icecc_pmbus_host.sv
module icecc_pmbus_host
(
	// clock and answer
	input  wire logic       ref_clk,
	input  wire logic       cmd_accept,
	// command strobe
	output logic            cmd_valid,
	output logic      [7:0] cmd_code,
	output logic            cmd_pec_used,
	output logic            cmd_pec_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_pec_used = 1'b0;
		cmd_pec_ok = 1'b0;
	end
	task automatic send(input logic [7:0] c, input logic pu, po, output logic a);
		@(negedge ref_clk);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_pec_used = pu;
		cmd_pec_ok = po;
		// hold the strobe up to the taking edge and read the answer there
		@(posedge ref_clk);
		a = cmd_accept;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		// released code must not look like the last one
		cmd_code = ~c;
	endtask : send
endmodule : icecc_pmbus_host

// ### tb/icecc_properties.sv
module icecc_properties
#(
	parameter int ERASE_CYCLES = 10,
	parameter int WDOG_CYCLES  = 50
)
(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// commands
	input wire logic        cmd_valid,
	input wire logic [7:0]  cmd_code,
	input wire logic        cmd_pec_used,
	input wire logic        cmd_pec_ok,
	input wire logic        cmd_accept,
	// fault log
	input wire logic        log_write,
	input wire logic [31:0] log_new_sum,
	input wire logic        log_sum_we,
	input wire logic [31:0] log_sum_wdata,
	input wire logic        log_erase,
	// parameter check
	input wire logic        param_valid,
	input wire logic [31:0] param_value,
	input wire logic [31:0] param_min,
	input wire logic [31:0] param_max,
	input wire logic        param_accept,
	input wire logic        param_reject,
	// status and pins
	input wire logic [31:0] cfg_sum_calc,
	input wire logic [31:0] cfg_sum_stored,
	input wire logic        cfg_fail_flag,
	input wire logic        use_factory_cfg,
	input wire logic        bus_alert_out_n,
	input wire logic        fw_running,
	input wire logic        loader_mode,
	input wire logic        init_done,
	input wire logic        wdog_kick,
	input wire logic [25:0] gpio_oe,
	input wire logic [11:0] fast_pulse_pins
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	int   ecnt, next_ecnt, wcnt, next_wcnt;
	logic in_rng;

	// ----
	// erase length and time since last kick
	// ----
	always_comb
	begin
		next_ecnt = log_erase ? ecnt + 1 : 0;
		// count clears to zero outside run, watchdog only runs there
		next_wcnt = (!fw_running || wdog_kick) ? 0 : wcnt + 1;
	end
	always_ff @(posedge ref_clk)
	begin
		ecnt <= rst ? 0 : next_ecnt;
		wcnt <= rst ? 0 : next_wcnt;
	end
	assign in_rng = param_value >= param_min && param_value <= param_max;

	sequence s_loader_cmd;
		cmd_accept && cmd_code == icecc_pkg::CMD_LOADER;
	endsequence
	sequence s_loader_on;
		loader_mode && !fw_running && fast_pulse_pins == '0;
	endsequence

	a_cmd_gate: assert property (cmd_accept == (cmd_valid && init_done &&
		!loader_mode && (!cmd_pec_used || cmd_pec_ok))) else $error("command gate wrong");
	a_loader_entry: assert property (s_loader_cmd |=> s_loader_on)
		else $error("loader mode not entered");
	a_log_update: assert property (log_write && fw_running |=> log_sum_we &&
		log_sum_wdata == $past(log_new_sum)) else $error("log sum not updated");
	a_param_check: assert property (param_valid |=> param_accept == $past(in_rng) &&
		param_reject == !$past(in_rng)) else $error("parameter range answer wrong");
	a_cfg_alert: assert property (fw_running |-> {cfg_fail_flag, use_factory_cfg,
		!bus_alert_out_n} == {3{cfg_sum_calc != cfg_sum_stored}}) else $error("config alert wrong");
	a_erase_len: assert property ($fell(log_erase) |-> ecnt == ERASE_CYCLES)
		else $error("erase length wrong");
	a_wdog_bound: assert property (wcnt <= WDOG_CYCLES + 2)
		else $error("watchdog did not expire");
	a_reset_quiet: assert property (disable iff (1'b0) rst && $past(rst) |->
		gpio_oe == '0 && fast_pulse_pins == '0 && bus_alert_out_n) else $error("pins active in reset");
endmodule : icecc_properties

bind icecc_top icecc_properties #(.ERASE_CYCLES(ERASE_CYCLES), .WDOG_CYCLES(WDOG_CYCLES))
	u_props (.*);

// ### tb/icecc_top_tb.sv
module icecc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int ER = 10;
	localparam int WD = 50;
	// startup checks take three edges before run, one before idle
	localparam int ST = 3;
	logic        ref_clk, rst, log_write, param_valid, wdog_kick, log_sum_we, log_erase;
	logic        cmd_valid, cmd_pec_used, cmd_pec_ok, cmd_accept, param_accept, param_reject;
	logic        fl_rd_corrected, fl_rd_bad, use_factory_cfg, cfg_fail_flag, bus_alert_out_n;
	logic        fw_running, loader_mode, init_done, sys_reset, acc;
	logic [7:0]  cmd_code;
	logic [11:0] fast_pulse_in, fast_pulse_pins;
	logic [25:0] gpio_drive, gpio_level, gpio_oe, gpio_out;
	logic [31:0] fw_sum_calc, fw_sum_stored, cfg_sum_calc, cfg_sum_stored, log_sum_calc;
	logic [31:0] log_sum_stored, log_new_sum, log_sum_wdata, param_value, param_min, param_max;
	logic [31:0] fl_wr_data, fl_rd_data, d;
	logic [37:0] fl_wr_code, fl_rd_code;
	int          fails, cmp_count, cyc, n;
	// model of parameter answers, pushed at drive and popped at result
	logic [1:0]  exp_q[$];

	icecc_top #(.ERASE_CYCLES(ER), .WDOG_CYCLES(WD)) dut (.*);
	icecc_pmbus_host host (.*);

	// ----
	// clock, timeout and checking helpers
	// ----
	initial
	begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			tally_and_finish();
		end
	end
	function automatic logic [5:0] ham(input logic [31:0] v);
		int i;
		ham = 6'h00;
		i = 0;
		for (int p = 3; p <= 38; p++)
		begin
			if ((p & (p - 1)) != 0)
			begin
				if (v[i])
					ham ^= 6'(p);
				i++;
			end
		end
	endfunction : ham
	task automatic chk(input string s, input logic [37:0] e, g);
		cmp_count++;
		if (g !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic tally_and_finish();
		if (fails == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	// ----
	// reset with chosen checksum faults, then wait for startup
	// ----
	task automatic boot(input logic fb, cb, lb);
		int e;
		n = 0;
		e = 0;
		rst = 1'b1;
		fw_sum_calc = $urandom;
		fw_sum_stored = fw_sum_calc ^ 32'(fb);
		cfg_sum_calc = $urandom;
		cfg_sum_stored = cfg_sum_calc ^ 32'(cb);
		log_sum_calc = $urandom;
		log_sum_stored = log_sum_calc ^ 32'(lb);
		repeat (3) @(negedge ref_clk);
		chk("reset_pins", 38'h0, 38'({gpio_oe, fast_pulse_pins}));
		chk("reset_alert", 38'h1, 38'(bus_alert_out_n));
		rst = 1'b0;
		while (init_done !== 1'b1 && n < 100)
		begin
			@(negedge ref_clk);
			n++;
			e += int'(log_erase === 1'b1);
		end
		chk("erase_cycles", 38'(!fb && lb ? ER : 0), 38'(e));
		if (!fb)
			chk("init_cycles", 38'(lb ? ST + ER : ST), 38'(n));
		else
			chk("idle_cycles", 38'h1, 38'(n));
		chk("status", 38'({!fb, !fb && cb, !fb && cb, fb || !cb}),
			38'({fw_running, cfg_fail_flag, use_factory_cfg, bus_alert_out_n}));
	endtask : boot

	// ----
	// running device: log, pins, parameters, ecc, commands
	// ----
	task automatic run_checks();
		int   off[4] = '{-1, 0, 20, 21};
		int   b;
		logic ok;
		gpio_drive = 26'($urandom);
		gpio_level = 26'($urandom);
		// never all zero, so a forced-low pin set is visible
		fast_pulse_in = 12'($urandom) | 12'h001;
		log_new_sum = $urandom;
		log_write = 1'b1;
		@(negedge ref_clk);
		log_write = 1'b0;
		chk("log_sum", {6'h01, log_new_sum}, {5'h00, log_sum_we, log_sum_wdata});
		chk("gpio_oe", 38'(gpio_drive & ~gpio_level), 38'(gpio_oe));
		chk("run_pins", 38'(fast_pulse_in), {gpio_out, fast_pulse_pins});
		param_valid = 1'b1;
		for (int k = 0; k < 6; k++)
		begin
			param_min = $urandom_range(100, 10);
			param_max = param_min + 20;
			param_value = k < 4 ? param_min + off[k] : $urandom_range(140, 0);
			ok = param_value >= param_min && param_value <= param_max;
			exp_q.push_back({ok, !ok});
			@(negedge ref_clk);
			chk("param", 38'(exp_q.pop_front()), 38'({param_accept, param_reject}));
		end
		param_valid = 1'b0;
		// a flip index of 38 shifts the mask out, leaving a clean word
		for (int k = 0; k < 8; k++)
		begin
			d = $urandom;
			b = $urandom_range(38, 0);
			fl_wr_data = d;
			fl_rd_code = {ham(d), d} ^ (38'h1 << b);
			@(negedge ref_clk);
			chk("ecc_write", {ham(d), d}, fl_wr_code);
			chk("ecc_read", {6'h00, d}, {5'h00, fl_rd_bad, fl_rd_data});
			chk("ecc_fixed", 38'(b < 38), 38'(fl_rd_corrected));
		end
		for (int k = 0; k < 4; k++)
		begin
			host.send(8'($urandom_range(200, 0)), k[1], k[0], acc);
			chk("cmd_pec", 38'(!k[1] || k[0]), 38'(acc));
		end
		host.send(8'hD9, 1'b1, 1'b0, acc);
		chk("loader_bad_pec", 38'h0, 38'({acc, loader_mode}));
		host.send(8'hD9, 1'b0, 1'b0, acc);
		chk("loader", 38'hC, 38'({acc, loader_mode, fw_running, fast_pulse_pins != '0}));
		host.send(8'h01, 1'b0, 1'b0, acc);
		chk("loader_cmd", 38'h0, 38'(acc));
	endtask : run_checks

	// ----
	// main sequence
	// ----
	initial
	begin
		rst = 1'b1;
		wdog_kick = 1'b1;
		{log_write, param_valid, param_value, param_min, param_max, log_new_sum} = '0;
		{gpio_drive, gpio_level, fast_pulse_in, fl_wr_data, fl_rd_code} = '0;
		void'($urandom(49));
		boot(1'b0, 1'b0, 1'b0);
		run_checks();
		boot(1'b0, 1'b1, 1'b0);
		boot(1'b0, 1'b0, 1'b1);
		boot(1'b1, 1'b0, 1'b0);
		host.send(8'h10, 1'b0, 1'b0, acc);
		chk("idle_cmd", 38'h1, 38'(acc));
		boot(1'b0, 1'b0, 1'b0);
		// stop kicking and time the expiry
		wdog_kick = 1'b0;
		n = 0;
		while (sys_reset !== 1'b1 && n < WD + 20)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk("wdog_time", 38'h1, 38'(n >= WD - 1 && n <= WD + 2));
		wdog_kick = 1'b1;
		@(negedge ref_clk);
		n = 0;
		while (init_done !== 1'b1 && n < 100)
		begin
			@(negedge ref_clk);
			n++;
		end
		chk("wdog_restart", 38'h1, 38'(fw_running));
		tally_and_finish();
	end
endmodule : icecc_top_tb

// ### verilog/icecc_hamming.sv
module icecc_hamming
(
	// write side
	input  wire logic [31:0] wr_data,
	output logic      [5:0]  wr_check,
	// read side
	input  wire logic [31:0] rd_data,
	input  wire logic [5:0]  rd_check,
	output logic      [31:0] rd_fixed,
	output logic             rd_corrected,
	output logic             rd_uncorrectable
);

	// ---------------------------------------------------------------
	// code positions
	// ---------------------------------------------------------------
	// data bit i sits at the i-th non power-of-two position from 3 up
	function automatic logic [5:0] pos_of(input int i);
		int p;
		int n;
		p = 0;
		n = -1;
		for (int k = 1; k < 64; k++)
		begin
			if (n < i && (k & (k - 1)) != 0)
			begin
				n = n + 1;
				p = k;
			end
		end
		return p[5:0];
	endfunction : pos_of

	// xor of positions of set data bits gives the check word
	function automatic logic [5:0] parity(input logic [31:0] d);
		logic [5:0] s;
		s = 6'h00;
		for (int i = 0; i < 32; i++)
		begin
			if (d[i])
				s = s ^ pos_of(i);
		end
		return s;
	endfunction : parity

	always_comb
	begin
		wr_check = parity(wr_data);
	end

	always_comb
	begin
		logic [5:0] syn;
		syn = parity(rd_data) ^ rd_check;
		rd_fixed = rd_data;
		rd_corrected = 1'b0;
		rd_uncorrectable = 1'b0;
		if (syn != icecc_pkg::SYN_NONE)
		begin
			rd_corrected = 1'b1;
			// check-bit flips leave data intact
			for (int i = 0; i < 32; i++)
			begin
				if (pos_of(i) == syn)
					rd_fixed[i] = ~rd_data[i];
			end
			if (syn > 6'(icecc_pkg::CODE_W))
				rd_uncorrectable = 1'b1;
		end
	end

endmodule : icecc_hamming

// ### verilog/icecc_pkg.sv
package icecc_pkg;

	// ---------------------------------------------------------------
	// widths and codes
	// ---------------------------------------------------------------
	localparam int          DATA_W      = 32;
	localparam int          CHK_W       = 6;
	localparam int          CODE_W      = 38;
	localparam int          GPIO_N      = 26;
	localparam int          FPP_N       = 12;
	localparam logic [7:0]  CMD_LOADER  = 8'hD9;
	localparam logic [5:0]  SYN_NONE    = 6'h00;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam longint      CLK_HZ      = 25000000;
	localparam longint      ERASE_MS    = 160;
	localparam longint      ERASE_CYC   = (ERASE_MS * CLK_HZ) / 1000;
	localparam int          WDOG_CYC    = 1000000;

	// ---------------------------------------------------------------
	// startup sequence, gray along the path through erase
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		ICECC_CHK_FW   = 3'b000,
		ICECC_CHK_CFG  = 3'b001,
		ICECC_CHK_LOG  = 3'b011,
		ICECC_ERASE    = 3'b010,
		ICECC_RUN      = 3'b110,
		ICECC_IDLE     = 3'b111,
		ICECC_LOADER   = 3'b101
	} icecc_state_e;

endpackage : icecc_pkg

// ### verilog/icecc_top.sv
module icecc_top
#(
	parameter int ERASE_CYCLES = int'(icecc_pkg::ERASE_CYC),
	parameter int WDOG_CYCLES  = icecc_pkg::WDOG_CYC
)
(
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// startup checksums
	input  wire logic [31:0] fw_sum_calc,
	input  wire logic [31:0] fw_sum_stored,
	input  wire logic [31:0] cfg_sum_calc,
	input  wire logic [31:0] cfg_sum_stored,
	input  wire logic [31:0] log_sum_calc,
	input  wire logic [31:0] log_sum_stored,
	// fault log writes
	input  wire logic        log_write,
	input  wire logic [31:0] log_new_sum,
	output logic             log_sum_we,
	output logic      [31:0] log_sum_wdata,
	output logic             log_erase,
	// bus commands
	input  wire logic        cmd_valid,
	input  wire logic [7:0]  cmd_code,
	input  wire logic        cmd_pec_used,
	input  wire logic        cmd_pec_ok,
	output logic             cmd_accept,
	// parameter check
	input  wire logic        param_valid,
	input  wire logic [31:0] param_value,
	input  wire logic [31:0] param_min,
	input  wire logic [31:0] param_max,
	output logic             param_accept,
	output logic             param_reject,
	// watchdog kick
	input  wire logic        wdog_kick,
	// flash ecc
	input  wire logic [31:0] fl_wr_data,
	output logic      [37:0] fl_wr_code,
	input  wire logic [37:0] fl_rd_code,
	output logic      [31:0] fl_rd_data,
	output logic             fl_rd_corrected,
	output logic             fl_rd_bad,
	// status
	output logic             use_factory_cfg,
	output logic             cfg_fail_flag,
	output logic             bus_alert_out_n,
	output logic             fw_running,
	output logic             loader_mode,
	output logic             init_done,
	output logic             sys_reset,
	// pins
	input  wire logic [25:0] gpio_drive,
	input  wire logic [25:0] gpio_level,
	output logic      [25:0] gpio_oe,
	output logic      [25:0] gpio_out,
	input  wire logic [11:0] fast_pulse_in,
	output logic      [11:0] fast_pulse_pins
);

	// ---------------------------------------------------------------
	// state and counters
	// ---------------------------------------------------------------
	icecc_pkg::icecc_state_e state;
	icecc_pkg::icecc_state_e next_state;
	logic [31:0]             erase_cnt;
	logic [31:0]             next_erase_cnt;
	logic [31:0]             wdog_cnt;
	logic [31:0]             next_wdog_cnt;
	logic                    wdog_rst;
	logic                    next_wdog_rst;
	logic                    cfg_fail;
	logic                    next_cfg_fail;
	logic                    dev_rst;

	// watchdog expiry resets everything, like the reset pin
	assign dev_rst = rst | wdog_rst;

	// ---------------------------------------------------------------
	// startup sequence
	// ---------------------------------------------------------------
	// next-state logic
	always_comb
	begin
		next_state     = state;
		next_erase_cnt = erase_cnt;
		next_cfg_fail  = cfg_fail;
		case (state)
			icecc_pkg::ICECC_CHK_FW:
			begin
				if (fw_sum_calc != fw_sum_stored)
					next_state = icecc_pkg::ICECC_IDLE;
				else
					next_state = icecc_pkg::ICECC_CHK_CFG;
			end
			icecc_pkg::ICECC_CHK_CFG:
			begin
				next_cfg_fail = (cfg_sum_calc != cfg_sum_stored);
				next_state    = icecc_pkg::ICECC_CHK_LOG;
			end
			icecc_pkg::ICECC_CHK_LOG:
			begin
				if (log_sum_calc != log_sum_stored)
				begin
					next_state     = icecc_pkg::ICECC_ERASE;
					next_erase_cnt = 32'h0000_0000;
				end
				else
					next_state = icecc_pkg::ICECC_RUN;
			end
			icecc_pkg::ICECC_ERASE:
			begin
				// startup held for the erase time
				if (erase_cnt >= 32'(ERASE_CYCLES - 1))
					next_state = icecc_pkg::ICECC_RUN;
				else
					next_erase_cnt = erase_cnt + 32'h0000_0001;
			end
			icecc_pkg::ICECC_RUN:
			begin
				if (cmd_accept && cmd_code == icecc_pkg::CMD_LOADER)
					next_state = icecc_pkg::ICECC_LOADER;
			end
			icecc_pkg::ICECC_IDLE:
			begin
				if (cmd_accept && cmd_code == icecc_pkg::CMD_LOADER)
					next_state = icecc_pkg::ICECC_LOADER;
			end
			icecc_pkg::ICECC_LOADER:
				next_state = icecc_pkg::ICECC_LOADER;
			default:
				next_state = icecc_pkg::ICECC_CHK_FW;
		endcase
	end

	// register sequence state
	always_ff @(posedge ref_clk)
	begin
		if (dev_rst)
		begin
			state     <= icecc_pkg::ICECC_CHK_FW;
			erase_cnt <= 32'h0000_0000;
			cfg_fail  <= 1'b0;
		end
		else
		begin
			state     <= next_state;
			erase_cnt <= next_erase_cnt;
			cfg_fail  <= next_cfg_fail;
		end
	end

	// ---------------------------------------------------------------
	// watchdog
	// ---------------------------------------------------------------
	// counts only while firmware runs; an idle device has nothing to kick it
	always_comb
	begin
		next_wdog_cnt = wdog_cnt;
		next_wdog_rst = 1'b0;
		if (state == icecc_pkg::ICECC_RUN)
		begin
			if (wdog_kick)
				next_wdog_cnt = 32'h0000_0000;
			else if (wdog_cnt >= 32'(WDOG_CYCLES - 1))
			begin
				next_wdog_rst = 1'b1;
				next_wdog_cnt = 32'h0000_0000;
			end
			else
				next_wdog_cnt = wdog_cnt + 32'h0000_0001;
		end
	end

	// watchdog registers; the pin reset and the expiry pulse both clear them
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			wdog_cnt <= 32'h0000_0000;
			wdog_rst <= 1'b0;
		end
		else
		begin
			wdog_cnt <= wdog_rst ? 32'h0000_0000 : next_wdog_cnt;
			wdog_rst <= wdog_rst ? 1'b0 : next_wdog_rst;
		end
	end

	// ---------------------------------------------------------------
	// status outputs
	// ---------------------------------------------------------------
	// factory configuration in use
	// alert low while config flag stands
	assign use_factory_cfg = cfg_fail;
	assign cfg_fail_flag   = cfg_fail;
	assign bus_alert_out_n = ~cfg_fail;
	assign fw_running      = (state == icecc_pkg::ICECC_RUN);
	assign loader_mode     = (state == icecc_pkg::ICECC_LOADER);
	assign init_done       = fw_running | loader_mode | (state == icecc_pkg::ICECC_IDLE);
	assign sys_reset       = dev_rst;
	// erase strobe held for the erase time
	assign log_erase       = (state == icecc_pkg::ICECC_ERASE);

	// ---------------------------------------------------------------
	// fault log checksum upkeep
	// ---------------------------------------------------------------
	// new entries rewrite the stored sum while firmware runs
	always_ff @(posedge ref_clk)
	begin
		if (dev_rst)
		begin
			log_sum_we    <= 1'b0;
			log_sum_wdata <= 32'h0000_0000;
		end
		else
		begin
			log_sum_we    <= log_write & fw_running;
			log_sum_wdata <= log_write ? log_new_sum : log_sum_wdata;
		end
	end

	// ---------------------------------------------------------------
	// commands and parameters
	// ---------------------------------------------------------------
	// pec optional; a present and wrong pec drops the command, as do loader mode and an unfinished startup
	assign cmd_accept = cmd_valid & init_done & ~loader_mode & (~cmd_pec_used | cmd_pec_ok);

	always_ff @(posedge ref_clk)
	begin
		if (dev_rst)
		begin
			param_accept <= 1'b0;
			param_reject <= 1'b0;
		end
		else
		begin
			param_accept <= param_valid & (param_value >= param_min) & (param_value <= param_max);
			param_reject <= param_valid & ((param_value < param_min) | (param_value > param_max));
		end
	end

	// ---------------------------------------------------------------
	// pins
	// ---------------------------------------------------------------
	// in reset gpio released and fast pulse pins low
	always_comb
	begin
		if (dev_rst || !fw_running)
		begin
			gpio_oe         = 26'h000_0000;
			gpio_out        = 26'h000_0000;
			fast_pulse_pins = 12'h000;
		end
		else
		begin
			// open drain: drive only a low
			gpio_oe         = gpio_drive & ~gpio_level;
			gpio_out        = 26'h000_0000;
			fast_pulse_pins = fast_pulse_in;
		end
	end

	// ---------------------------------------------------------------
	// flash ecc
	// ---------------------------------------------------------------
	logic [5:0] wr_chk;

	// check bits stored beside the word
	assign fl_wr_code = {wr_chk, fl_wr_data};

	icecc_hamming u_ecc
	(
		.wr_data          (fl_wr_data),
		.wr_check         (wr_chk),
		.rd_data          (fl_rd_code[31:0]),
		.rd_check         (fl_rd_code[37:32]),
		.rd_fixed         (fl_rd_data),
		.rd_corrected     (fl_rd_corrected),
		.rd_uncorrectable (fl_rd_bad)
	);

endmodule : icecc_top
